/* File: hdl/scimg_consts.vh */
// Constants for the system-control interrupt mask stage
// Contract
// - PLL-lock enable bit 6 with its raw flag set raises the interrupt.
// - Current-limit enable bit 5 with its raw flag set raises the interrupt.
// - Internal-oscillator-fault enable bit 4 with raw flag raises the interrupt.
// - Main-oscillator-fault enable bit 3 with raw flag raises the interrupt.
// - Regulator-unregulated enable bit 2 with raw flag raises the interrupt.
// - Brown-out enable bit 1 with raw flag raises the interrupt while reset selection is cleared.
// - PLL-fault enable bit 0 with raw flag raises the interrupt.
// - Mask bits 31 to 7 are read-only; writes there do nothing.
// - Raw flags are set only by hardware, never by a raw register write.
// - Masked status equals raw AND enable, with brown-out also gated off by reset selection, and drives the interrupt.
// - Writing one to a masked bit clears it and its raw flag.
// - Brown-out interrupts only when enabled and reset selection is cleared.
`ifndef SCIMG_CONSTS_VH
`define SCIMG_CONSTS_VH

`define SCIMG_NUM_SRC 7
`define SCIMG_ADDR_W 12
`define SCIMG_DATA_W 32

`define SCIMG_OFF_RAW_STATUS 12'h050
`define SCIMG_OFF_ENABLE_MASK 12'h054
`define SCIMG_OFF_MASKED_STATUS 12'h058
`define SCIMG_OFF_BROWNOUT_CTRL 12'h070

`define SCIMG_BIT_PLL_FAULT 0
`define SCIMG_BIT_BROWNOUT 1
`define SCIMG_BIT_REGULATOR 2
`define SCIMG_BIT_MAIN_OSC 3
`define SCIMG_BIT_INT_OSC 4
`define SCIMG_BIT_CURRENT_LIMIT 5
`define SCIMG_BIT_PLL_LOCK 6
`define SCIMG_BIT_BOR_RESET_SELECT 1

`define SCIMG_RST_ENABLE_MASK 7'h00
`define SCIMG_RST_RAW_STATUS 7'h00
`define SCIMG_RST_BOR_SELECT 1'b0
`define SCIMG_READ_ZERO 32'h00000000

`endif

/* File: hdl/scimg_event_sync.v */
// Three-stage synchroniser with agreement filter for detector levels
`timescale 1ns/1ps
`include "scimg_consts.vh"
module scimg_event_sync (
  input wire clock,
  input wire rst_n,
  input wire [`SCIMG_NUM_SRC-1:0] eventIn,
  output wire [`SCIMG_NUM_SRC-1:0] eventLevel,
  output wire [`SCIMG_NUM_SRC-1:0] eventRise
);
  reg [`SCIMG_NUM_SRC-1:0] stage1_q;
  reg [`SCIMG_NUM_SRC-1:0] stage2_q;
  reg [`SCIMG_NUM_SRC-1:0] stage3_q;
  reg [`SCIMG_NUM_SRC-1:0] level_q;
  wire [`SCIMG_NUM_SRC-1:0] agree;
  wire [`SCIMG_NUM_SRC-1:0] level_d;

  // Only stages two and three are compared; stage one may be metastable
  assign agree = ~(stage2_q ^ stage3_q);
  assign level_d = (agree & stage3_q) | (~agree & level_q);
  assign eventRise = level_d & ~level_q;
  assign eventLevel = level_q;

  always @(posedge clock) begin
    if (!rst_n) begin
      stage1_q <= {`SCIMG_NUM_SRC{1'b0}};
      stage2_q <= {`SCIMG_NUM_SRC{1'b0}};
      stage3_q <= {`SCIMG_NUM_SRC{1'b0}};
      level_q <= {`SCIMG_NUM_SRC{1'b0}};
    end else begin
      stage1_q <= eventIn;
      stage2_q <= stage1_q;
      stage3_q <= stage2_q;
      level_q <= level_d;
    end
  end
endmodule // scimg_event_sync

/* File: hdl/scimg_interrupt_mask_gate.v */
// System-control interrupt mask stage with APB register slave
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
`include "scimg_consts.vh"
module scimg_interrupt_mask_gate (
  input wire clock,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`SCIMG_ADDR_W-1:0] paddr,
  input wire [`SCIMG_DATA_W-1:0] pwdata,
  input wire [3:0] pstrb,
  output wire pready,
  output wire [`SCIMG_DATA_W-1:0] prdata,
  output wire pslverr,
  input wire pllLockEvent,
  input wire currentLimitEvent,
  input wire internalOscFaultEvent,
  input wire mainOscFaultEvent,
  input wire regulatorUnregulatedEvent,
  input wire brownoutEvent,
  input wire pllFaultEvent,
  output wire irqReq,
  output wire brownoutResetReq,
  output wire [`SCIMG_NUM_SRC-1:0] maskedStatus
);

  // Address match on the word; the two low address bits are ignored
  function addrIs;
    input [`SCIMG_ADDR_W-1:0] addr;
    input [`SCIMG_ADDR_W-1:0] offset;
    begin
      addrIs = (addr[`SCIMG_ADDR_W-1:2] == offset[`SCIMG_ADDR_W-1:2]);
    end
  endfunction

  function mapped;
    input [`SCIMG_ADDR_W-1:0] addr;
    begin
      mapped = addrIs(addr, `SCIMG_OFF_RAW_STATUS)
        | addrIs(addr, `SCIMG_OFF_ENABLE_MASK)
        | addrIs(addr, `SCIMG_OFF_MASKED_STATUS)
        | addrIs(addr, `SCIMG_OFF_BROWNOUT_CTRL);
    end
  endfunction

  // Seven sources widened to a bus word, upper bits zero
  function [`SCIMG_DATA_W-1:0] widen;
    input [`SCIMG_NUM_SRC-1:0] bits;
    begin
      widen = {{(`SCIMG_DATA_W-`SCIMG_NUM_SRC){1'b0}}, bits};
    end
  endfunction

  wire [`SCIMG_NUM_SRC-1:0] eventPins;
  wire [`SCIMG_NUM_SRC-1:0] eventLevel;
  wire [`SCIMG_NUM_SRC-1:0] eventRise;

  reg [`SCIMG_NUM_SRC-1:0] enableMask_q;
  reg [`SCIMG_NUM_SRC-1:0] enableMask_d;
  reg [`SCIMG_NUM_SRC-1:0] rawStatus_q;
  reg [`SCIMG_NUM_SRC-1:0] rawStatus_d;
  reg borResetSelect_q;
  reg borResetSelect_d;
  reg [`SCIMG_NUM_SRC-1:0] masked_q;
  reg [`SCIMG_NUM_SRC-1:0] masked_d;
  reg irq_q;
  reg irq_d;
  reg borReset_q;
  reg borReset_d;
  reg [`SCIMG_DATA_W-1:0] rdata_q;
  reg [`SCIMG_DATA_W-1:0] rdata_d;
  reg slverr_q;
  reg slverr_d;

  wire setupPhase;
  wire accessPhase;
  wire writeAccess;
  wire lowByteWrite;
  wire writeEnableMask;
  wire writeMaskedClear;
  wire writeBorControl;
  wire [`SCIMG_NUM_SRC-1:0] clearRequest;
  wire [`SCIMG_NUM_SRC-1:0] gateMask;

  assign eventPins[`SCIMG_BIT_PLL_LOCK] = pllLockEvent;
  assign eventPins[`SCIMG_BIT_CURRENT_LIMIT] = currentLimitEvent;
  assign eventPins[`SCIMG_BIT_INT_OSC] = internalOscFaultEvent;
  assign eventPins[`SCIMG_BIT_MAIN_OSC] = mainOscFaultEvent;
  assign eventPins[`SCIMG_BIT_REGULATOR] = regulatorUnregulatedEvent;
  assign eventPins[`SCIMG_BIT_BROWNOUT] = brownoutEvent;
  assign eventPins[`SCIMG_BIT_PLL_FAULT] = pllFaultEvent;

  // Detectors may sit on other oscillators, so every event is synchronised
  scimg_event_sync eventSync (
    .clock(clock),
    .rst_n(rst_n),
    .eventIn(eventPins),
    .eventLevel(eventLevel),
    .eventRise(eventRise)
  );

  // Zero wait states: read data is captured in the setup cycle
  assign setupPhase = psel & ~penable;
  assign accessPhase = psel & penable;
  assign pready = 1'b1;
  assign prdata = rdata_q;
  assign pslverr = slverr_q;
  assign writeAccess = accessPhase & pwrite;
  // All live fields sit in byte lane zero
  assign lowByteWrite = writeAccess & pstrb[0];
  assign writeEnableMask = lowByteWrite & addrIs(paddr, `SCIMG_OFF_ENABLE_MASK);
  assign writeMaskedClear = lowByteWrite & addrIs(paddr, `SCIMG_OFF_MASKED_STATUS);
  assign writeBorControl = lowByteWrite & addrIs(paddr, `SCIMG_OFF_BROWNOUT_CTRL);

  assign clearRequest = writeMaskedClear ? pwdata[`SCIMG_NUM_SRC-1:0]
    : {`SCIMG_NUM_SRC{1'b0}};

  // Enable mask register
  always @* begin
    enableMask_d = enableMask_q;
    if (writeEnableMask) begin
      enableMask_d = pwdata[`SCIMG_NUM_SRC-1:0];
    end
  end

  // Brown-out reset selection
  always @* begin
    borResetSelect_d = borResetSelect_q;
    if (writeBorControl) begin
      borResetSelect_d = pwdata[`SCIMG_BIT_BOR_RESET_SELECT];
    end
  end

  // Raw flags: a new detection in the clearing cycle survives the clear
  always @* begin
    rawStatus_d = (rawStatus_q & ~clearRequest) | eventRise;
  end

  // Gate for every source; brown-out is withheld while it is routed to reset
  // Brown-out reset route
  assign gateMask = {enableMask_d[`SCIMG_BIT_PLL_LOCK],
    enableMask_d[`SCIMG_BIT_CURRENT_LIMIT],
    enableMask_d[`SCIMG_BIT_INT_OSC],
    enableMask_d[`SCIMG_BIT_MAIN_OSC],
    enableMask_d[`SCIMG_BIT_REGULATOR],
    enableMask_d[`SCIMG_BIT_BROWNOUT] & ~borResetSelect_d,
    enableMask_d[`SCIMG_BIT_PLL_FAULT]};

  always @* begin
    masked_d = {`SCIMG_NUM_SRC{1'b0}};
    masked_d = rawStatus_d & gateMask;
    masked_d[`SCIMG_BIT_PLL_LOCK] = rawStatus_d[`SCIMG_BIT_PLL_LOCK]
      & gateMask[`SCIMG_BIT_PLL_LOCK];
    masked_d[`SCIMG_BIT_CURRENT_LIMIT] = rawStatus_d[`SCIMG_BIT_CURRENT_LIMIT]
      & gateMask[`SCIMG_BIT_CURRENT_LIMIT];
    masked_d[`SCIMG_BIT_INT_OSC] = rawStatus_d[`SCIMG_BIT_INT_OSC]
      & gateMask[`SCIMG_BIT_INT_OSC];
    masked_d[`SCIMG_BIT_MAIN_OSC] = rawStatus_d[`SCIMG_BIT_MAIN_OSC]
      & gateMask[`SCIMG_BIT_MAIN_OSC];
    masked_d[`SCIMG_BIT_REGULATOR] = rawStatus_d[`SCIMG_BIT_REGULATOR]
      & gateMask[`SCIMG_BIT_REGULATOR];
    masked_d[`SCIMG_BIT_BROWNOUT] = rawStatus_d[`SCIMG_BIT_BROWNOUT]
      & gateMask[`SCIMG_BIT_BROWNOUT];
    masked_d[`SCIMG_BIT_PLL_FAULT] = rawStatus_d[`SCIMG_BIT_PLL_FAULT]
      & gateMask[`SCIMG_BIT_PLL_FAULT];
  end

  // Request registered from next state so it tracks the status exactly
  always @* begin
    irq_d = |masked_d;
    // Reset request follows the live level, not the sticky flag
    borReset_d = eventLevel[`SCIMG_BIT_BROWNOUT] & borResetSelect_d;
  end

  // Read data mux, sampled during the setup cycle
  always @* begin
    rdata_d = rdata_q;
    slverr_d = 1'b0;
    if (setupPhase) begin
      rdata_d = `SCIMG_READ_ZERO;
      slverr_d = ~mapped(paddr);
      if (!pwrite) begin
        if (addrIs(paddr, `SCIMG_OFF_RAW_STATUS)) begin
          rdata_d = widen(rawStatus_q);
        end else if (addrIs(paddr, `SCIMG_OFF_ENABLE_MASK)) begin
          rdata_d = widen(enableMask_q);
        end else if (addrIs(paddr, `SCIMG_OFF_MASKED_STATUS)) begin
          rdata_d = widen(masked_q);
        end else if (addrIs(paddr, `SCIMG_OFF_BROWNOUT_CTRL)) begin
          rdata_d[`SCIMG_BIT_BOR_RESET_SELECT] = borResetSelect_q;
        end
      end
    end else if (accessPhase) begin
      slverr_d = slverr_q;
    end
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      enableMask_q <= `SCIMG_RST_ENABLE_MASK;
      rawStatus_q <= `SCIMG_RST_RAW_STATUS;
      borResetSelect_q <= `SCIMG_RST_BOR_SELECT;
      masked_q <= {`SCIMG_NUM_SRC{1'b0}};
      irq_q <= 1'b0;
      borReset_q <= 1'b0;
      rdata_q <= `SCIMG_READ_ZERO;
      slverr_q <= 1'b0;
    end else begin
      enableMask_q <= enableMask_d;
      rawStatus_q <= rawStatus_d;
      borResetSelect_q <= borResetSelect_d;
      masked_q <= masked_d;
      irq_q <= irq_d;
      borReset_q <= borReset_d;
      rdata_q <= rdata_d;
      slverr_q <= slverr_d;
    end
  end

  assign irqReq = irq_q;
  assign brownoutResetReq = borReset_q;
  assign maskedStatus = masked_q;

endmodule // scimg_interrupt_mask_gate

/* File: test/scimg_mask_gate_sva.sv */
// Assertion checker for the interrupt mask stage
`timescale 1ns/1ps
module scimg_mask_gate_sva (
  input logic clock,
  input logic rst_n,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [3:0] pstrb,
  input logic [31:0] prdata,
  input logic pslverr,
  input logic pllLockEvent,
  input logic currentLimitEvent,
  input logic internalOscFaultEvent,
  input logic mainOscFaultEvent,
  input logic regulatorUnregulatedEvent,
  input logic brownoutEvent,
  input logic pllFaultEvent,
  input logic irqReq,
  input logic brownoutResetReq,
  input logic [6:0] maskedStatus
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire [6:0] ev = {pllLockEvent, currentLimitEvent, internalOscFaultEvent, mainOscFaultEvent,
    regulatorUnregulatedEvent, brownoutEvent, pllFaultEvent};
  wire wrAcc = psel & penable & pwrite;
  wire [9:0] wa = paddr[11:2];
  wire mapped = (wa == 10'h014) | (wa == 10'h015) | (wa == 10'h016) | (wa == 10'h01C);
  sequence s_w1c;
    wrAcc && pstrb[0] && wa == 10'h016;
  endsequence
  property p_irq_or; irqReq == (|maskedStatus); endproperty
  a_irq_or: assert property (p_irq_or) else $error("request not OR of masked");
  property p_reset; $rose(rst_n) |-> maskedStatus == 7'h00 && !irqReq; endproperty
  a_reset: assert property (p_reset) else $error("masked set after reset");
  // A masked bit may only rise from a held event or a register write
  property p_rise;
    !$past(wrAcc) |-> (maskedStatus & ~$past(maskedStatus) & ~$past(ev, 2)) == 7'h00;
  endproperty
  a_rise: assert property (p_rise) else $error("masked bit without cause");
  property p_w1c; s_w1c |=> (maskedStatus & $past(pwdata[6:0])) == 7'h00; endproperty
  a_w1c: assert property (p_w1c) else $error("clear write ignored");
  property p_err; psel && !penable |=> pslverr != mapped; endproperty
  a_err: assert property (p_err) else $error("error flag wrong");
  property p_rsvd; psel && penable && !pwrite |-> prdata[31:7] == 25'h0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits nonzero");
  property p_bor; $rose(brownoutResetReq) |-> !maskedStatus[1]; endproperty
  a_bor: assert property (p_bor) else $error("brownout both reset and irq");
  property p_raw_ro; wrAcc && wa == 10'h014 |=> $stable(maskedStatus); endproperty
  a_raw_ro: assert property (p_raw_ro) else $error("raw write changed state");
endmodule // scimg_mask_gate_sva

/* File: test/scimg_detector_model.sv */
// Fault detector model: each fire pulse gives a level held twelve cycles
`timescale 1ns/1ps
module scimg_detector_model (
  input logic clock,
  input logic [6:0] fire,
  output logic pllLockEvent,
  output logic currentLimitEvent,
  output logic internalOscFaultEvent,
  output logic mainOscFaultEvent,
  output logic regulatorUnregulatedEvent,
  output logic brownoutEvent,
  output logic pllFaultEvent
);
  logic [3:0] hold [0:6] = '{default: 4'h0};
  logic [6:0] lvl = 7'h00;
  integer i;
  // Hardware-only events; held long so the filter never drops them
  always @(posedge clock) begin
    for (i = 0; i < 7; i++) begin
      lvl[i] <= fire[i] || hold[i] > 4'h1;
      hold[i] <= fire[i] ? 4'hC : (hold[i] != 4'h0 ? hold[i] - 4'h1 : 4'h0);
    end
  end
  assign {pllLockEvent, currentLimitEvent, internalOscFaultEvent, mainOscFaultEvent,
    regulatorUnregulatedEvent, brownoutEvent, pllFaultEvent} = lvl;
endmodule // scimg_detector_model

/* File: test/testbench.sv */
// Self-checking bench for the interrupt mask stage
`timescale 1ns/1ps
module testbench;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'hF;
  logic [6:0] fire = 7'h00;
  wire pready, pslverr, irqReq, brownoutResetReq;
  wire [31:0] prdata;
  wire [6:0] maskedStatus;
  wire pllLockEvent, currentLimitEvent, internalOscFaultEvent, mainOscFaultEvent;
  wire regulatorUnregulatedEvent, brownoutEvent, pllFaultEvent;
  logic [31:0] seed = 32'h8458CF99;
  logic [31:0] rdat, rerr, d;
  integer n_mismatch = 0, total_checks = 0, en = 0, raw = 0, sel = 0, i, ms;
  always #12.5 clock = ~clock;
  scimg_interrupt_mask_gate i_scimg_interrupt_mask_gate (.*);
  scimg_detector_model i_scimg_detector_model (.*);
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Setup then access; request held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never completes
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Outputs launched at the access edge are only settled one edge later
  task automatic expect_state();
    @(posedge clock);
    ms = raw & en & ~(sel ? 2 : 0);
    chk("masked", maskedStatus, ms);
    chk("irq", irqReq, ms != 0);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    apb(0, 12'h054, 0);
    chk("mask reset", rdat, 0);
    chk("ready", pready, 1);
    d = xs();
    apb(1, 12'h054, d);
    apb(0, 12'h054, 0);
    chk("mask rw", rdat, d & 32'h7F);
    chk("mapped err", rerr, 0);
    $display("done: reset and mask");
    // to each enable, plus one disabled source
    for (i = 0; i < 7; i++) begin
      en = 1 << i;
      apb(1, 12'h054, (xs() & 32'hFFFFFF80) | en);
      fire <= 7'((1 << i) | (1 << ((i + 3) % 7)));
      @(posedge clock);
      fire <= 7'h00;
      repeat (8) @(posedge clock);
      raw = (1 << i) | (1 << ((i + 3) % 7));
      expect_state();
      apb(0, 12'h058, 0);
      chk("masked read", rdat, ms);
      apb(1, 12'h050, xs());
      apb(0, 12'h050, 0);
      chk("raw", rdat, raw);
      apb(1, 12'h058, raw);
      raw = 0;
      expect_state();
      apb(0, 12'h050, 0);
      chk("raw cleared", rdat, 0);
      repeat (8) @(posedge clock);
    end
    $display("done: sources");
    apb(1, 12'h070, 2);
    sel = 1;
    en = 32'h7F;
    apb(1, 12'h054, en);
    fire <= 7'h02;
    @(posedge clock);
    fire <= 7'h00;
    repeat (8) @(posedge clock);
    raw = 2;
    expect_state();
    chk("bor reset", brownoutResetReq, 1);
    apb(0, 12'h070, 0);
    chk("select read", rdat, 2);
    apb(1, 12'h070, 0);
    sel = 0;
    expect_state();
    chk("bor no reset", brownoutResetReq, 0);
    apb(1, 12'h058, 2);
    raw = 0;
    expect_state();
    $display("done: brownout");
    apb(0, 12'h100, 0);
    chk("unmapped err", rerr, 1);
    chk("unmapped data", rdat, 0);
    apb(1, 12'h104, xs());
    chk("unmapped werr", rerr, 1);
    // Byte lane zero off, so the write must not land
    pstrb <= 4'hE;
    apb(1, 12'h054, 0);
    pstrb <= 4'hF;
    apb(0, 12'h054, 0);
    chk("lane gated", rdat, en);
    $display("done: unmapped");
    // second reset with every enable set
    rst_n <= 1'b0;
    en = 0;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    apb(0, 12'h054, 0);
    chk("mask re-reset", rdat, 0);
    apb(0, 12'h070, 0);
    chk("select reset", rdat, 0);
    expect_state();
    $display("done: second reset");
    wrap_up();
  end
  // Whole run is under two thousand cycles
  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    wrap_up();
  end
endmodule // testbench
bind scimg_interrupt_mask_gate scimg_mask_gate_sva i_scimg_mask_gate_sva (.*);
